/* File: cardbus_function_event_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module cardbus_function_event_regs_tb;
  logic CLK = 0, RESET = 1, CARDBUS_MODE = 1, STATUS_REGS_ENABLE = 1, go = 0, wr = 0;
  logic WAKE_REQ = 0, IRQ_REQ = 0, PM_EVENT_ENABLE = 0, PM_ENABLE_WR = 0, PM_STATUS_CLR_WR = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] data = 32'h0;
  wire REG_SEL, REG_WR, REG_RD, PM_STATUS_CLR, CARD_IRQ_PIN, CARD_STATUS_CHANGE_PIN, ACTIVE;
  wire [7:0] REG_ADDR;
  wire [31:0] REG_WDATA, REG_RDATA;
  int n_errors = 0, comparisons = 0, cyc = 0, lat = 0, msk = 0, pw = 0, pi = 0, xr = 0, xc = 0, st, cl, a;
  bit on;
  initial forever #50 CLK = ~CLK;
  cbfe_host host (.*);
  cbfe_function_event_regs uut (.*);
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // slow bus: hang limit well above the run
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      conclude;
    end
  end
  initial begin
    a = $urandom(22);
    repeat (8) @(negedge CLK);
    RESET = 0;
    repeat (2000) begin
      @(negedge CLK);
      a = $urandom;
      data = $urandom;
      STATUS_REGS_ENABLE = a[3:0] != 0;
      CARDBUS_MODE = a[7:4] != 0;
      // live requests held while idle, so edge history stays aligned
      if (CARDBUS_MODE && STATUS_REGS_ENABLE) begin
        WAKE_REQ = a[8];
        IRQ_REQ = a[9] & a[10];
      end
      go = a[11] | a[12];
      wr = a[13];
      addr = 8'(a[16:14] % 5 * 4);
      PM_EVENT_ENABLE = a[17];
      PM_ENABLE_WR = a[18] & a[19] & a[20];
      PM_STATUS_CLR_WR = a[21] & a[22] & a[23];
      @(posedge CLK);
      on = CARDBUS_MODE && STATUS_REGS_ENABLE;
      xr = 0;
      xc = 0;
      if (on) begin
        if (go && !wr)
          xr = addr == 0 ? lat : addr == 4 ? msk : addr == 8 ? WAKE_REQ << 4 | IRQ_REQ << 15 | 14 : 0;
        st = (WAKE_REQ && !pw ? 16 : 0) | (IRQ_REQ && !pi ? 32768 : 0);
        st |= go && wr && addr == 8'h0C ? data & 32'h8010 : 0;
        cl = (go && wr && addr == 0 ? data & 32'h8010 : 0) | (PM_STATUS_CLR_WR ? 16 : 0);
        lat = lat & ~cl | st;
        xc = go && wr && addr == 0 && data[4];
        if (go && wr && addr == 4) msk = data & 32'hC010;
        if (PM_ENABLE_WR) msk = msk & 32'h8000 | (PM_EVENT_ENABLE ? 32'h4010 : 0);
        pw = WAKE_REQ;
        pi = IRQ_REQ;
      end
      #1;
      `CHK(REG_RDATA, 32'(xr))
      `CHK(PM_STATUS_CLR, 1'(xc))
      `CHK(CARD_IRQ_PIN, 1'(on && lat[15] && msk[15]))
      `CHK(CARD_STATUS_CHANGE_PIN, 1'(on && lat[4] && msk[4] && msk[14]))
      `CHK(ACTIVE, on)
    end
    conclude;
  end
endmodule // cardbus_function_event_regs_tb
`default_nettype wire

/* File: cbfe_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module cbfe_chk (
  input wire CLK, RESET, ACTIVE, REG_SEL, REG_WR, REG_RD, WAKE_REQ, IRQ_REQ, PM_STATUS_CLR_WR,
  input wire PM_STATUS_CLR, CARD_IRQ_PIN, CARD_STATUS_CHANGE_PIN,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA, REG_RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire rd = ACTIVE && REG_SEL && REG_RD;
  wire w0 = ACTIVE && REG_SEL && REG_WR && REG_ADDR == 8'h00;
  wire w04 = w0 && REG_WDATA[4];
  wire fw = REG_SEL && REG_WR && REG_ADDR == 8'h0C;
  a_pins_idle: assert property (!ACTIVE |-> !CARD_IRQ_PIN && !CARD_STATUS_CHANGE_PIN)
    else $error("pin high while idle");
  a_live_read: assert property (rd && REG_ADDR == 8'h08 |=> REG_RDATA[4] == $past(WAKE_REQ)
    && REG_RDATA[15] == $past(IRQ_REQ) && REG_RDATA[3:0] == 4'hE) else $error("live read");
  a_low_nibble: assert property (rd && REG_ADDR != 8'h08 |=> REG_RDATA[3:0] == 4'h0) else $error("low bits");
  a_rsvd_zero: assert property (REG_RDATA[31:16] == 16'h0 && REG_RDATA[13:5] == 9'h0) else $error("rsvd");
  a_idle_rdata: assert property (!rd |=> REG_RDATA == 32'h0) else $error("rdata idle");
  a_pm_clr: assert property (PM_STATUS_CLR == $past(w04)) else $error("pm clear");
  a_irq_clear: assert property (w0 && REG_WDATA[15] && !$rose(IRQ_REQ) |=> !CARD_IRQ_PIN)
    else $error("irq clear");
  a_stat_clear: assert property (ACTIVE && PM_STATUS_CLR_WR && !$rose(WAKE_REQ) && !fw
    |=> !CARD_STATUS_CHANGE_PIN) else $error("status clear");
  c_irq: cover property (CARD_IRQ_PIN);
  c_stat: cover property (CARD_STATUS_CHANGE_PIN);
  c_live: cover property (rd && REG_ADDR == 8'h08);
endmodule // cbfe_chk
bind cbfe_function_event_regs cbfe_chk u_chk (.*);
`default_nettype wire

/* File: cbfe_function_event_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "cbfe_regs.vh"
// Notes on behaviour
// - four 32-bit registers at offsets 00, 04, 08, 0C in the fifth base region
// - registers act only while the local enable is set, else bypassed
// - only in cardbus mode; pci mode sees no effect on irq or wake
// - event latch holds wake in bit 4, irq/powerdown in bit 15
// - writing 1 clears a latched event bit; 0 leaves it
// - bits 0 to 3 of latch and mask read as zero
// - latched bit drives its pin only when its mask bits are set
// - mask register gates the irq line and the status-change line
// - mask bits 4 and 14 track pm enable, reset to zero
// - status-change asserts for wake only while mask 4 and 14 both set
// - mask bit 15 gates the irq line, resets to zero
// - live register returns unlatched wake in bit 4, irq in bit 15
// - live bit 0 reads 0; bits 1 to 3 read 1
// - force register has no storage; writes act on the event latch
// - force bit 4 sets latched wake, live wake unchanged
// - force bit 15 sets latched irq, live irq unchanged
// - real events after a forced write may still set latch bits
// - pm enable written 1 sets mask 4 and 14; written 0 clears them
// - writing 1 to pm status clears latched wake bit
// - writing 1 to latched wake bit also clears pm status
// - clearing mask 4 and 14 leaves pm enable alone
module cbfe_function_event_regs (
  // clock and reset
  input wire CLK,
  input wire RESET,
  // mode and enable
  input wire CARDBUS_MODE,
  input wire STATUS_REGS_ENABLE,
  // register access in the fifth base region
  input wire REG_SEL,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  output wire [31:0] REG_RDATA,
  // internal requests
  input wire WAKE_REQ,
  input wire IRQ_REQ,
  // power-management block coupling
  input wire PM_EVENT_ENABLE,
  input wire PM_ENABLE_WR,
  input wire PM_STATUS_CLR_WR,
  output wire PM_STATUS_CLR,
  // card pins, active high requests, and the active flag
  output wire CARD_IRQ_PIN,
  output wire CARD_STATUS_CHANGE_PIN,
  output wire ACTIVE
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire active;
  wire wr;
  wire rd;
  wire wr_latch;
  wire wr_mask;
  wire wr_force;
  wire pm_wr;
  wire sw_wake_one;
  wire sw_irq_one;
  wire force_wake_one;
  wire force_irq_one;
  wire pm_status_one;
  wire wake_rise;
  wire irq_rise;
  wire wake_set;
  wire irq_set;
  wire wake_clr;
  wire irq_clr;
  wire wake_gate;
  wire pin_irq;
  wire pin_wake;
  reg wake_latch_ff;
  reg irq_latch_ff;
  reg general_wake_mask_ff;
  reg wake_mask_bit_ff;
  reg irq_mask_ff;
  reg wake_prev_ff;
  reg irq_prev_ff;
  reg pm_clr_ff;
  reg nxt_wake_latch;
  reg nxt_irq_latch;
  reg nxt_general_wake_mask;
  reg nxt_wake_mask_bit;
  reg nxt_irq_mask;
  reg nxt_wake_prev;
  reg nxt_irq_prev;
  reg nxt_pm_clr;
  reg [31:0] latch_word;
  reg [31:0] mask_word;
  reg [31:0] live_word;
  reg [31:0] rd_mux;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // address compare, shared by every strobe decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // sticky bit update; set beats clear so no event is lost
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      if (set) begin
        sticky = 1'b1;
      end else if (clr) begin
        sticky = 1'b0;
      end else begin
        sticky = cur;
      end
    end
  endfunction

  // places the two event bits into a word, all else zero
  function [31:0] pack_events;
    input b4;
    input b15;
    begin
      pack_events = `CBFE_ZERO;
      pack_events[`CBFE_BIT_WAKE] = b4;
      pack_events[`CBFE_BIT_IRQ] = b15;
    end
  endfunction

  // ----------------------------------------
  // gating and decode
  // ----------------------------------------
  // bypassed unless cardbus mode and local enable
  assign active = CARDBUS_MODE & STATUS_REGS_ENABLE;
  assign ACTIVE = active;
  assign wr = active & REG_SEL & REG_WR;
  assign rd = active & REG_SEL & REG_RD;
  assign wr_latch = wr & hit(REG_ADDR, `CBFE_OFS_LATCH);
  assign wr_mask = wr & hit(REG_ADDR, `CBFE_OFS_MASK);
  assign wr_force = wr & hit(REG_ADDR, `CBFE_OFS_FORCE);
  assign pm_wr = active & PM_ENABLE_WR;
  assign sw_wake_one = wr_latch & REG_WDATA[`CBFE_BIT_WAKE];
  assign sw_irq_one = wr_latch & REG_WDATA[`CBFE_BIT_IRQ];
  assign force_wake_one = wr_force & REG_WDATA[`CBFE_BIT_WAKE];
  assign force_irq_one = wr_force & REG_WDATA[`CBFE_BIT_IRQ];
  assign pm_status_one = active & PM_STATUS_CLR_WR;

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  // rising edge only, so a held request does not refill a cleared latch
  assign wake_rise = active & WAKE_REQ & ~wake_prev_ff;
  assign irq_rise = active & IRQ_REQ & ~irq_prev_ff;
  assign wake_set = wake_rise | force_wake_one;
  assign irq_set = irq_rise | force_irq_one;
  assign wake_clr = sw_wake_one | pm_status_one;
  assign irq_clr = sw_irq_one;

  always @* begin
    nxt_wake_prev = WAKE_REQ;
  end

  always @* begin
    nxt_irq_prev = IRQ_REQ;
  end

  // history runs even when bypassed, so enabling gives no false edge
  always @(posedge CLK) begin
    if (RESET) begin
      wake_prev_ff <= 1'b0;
    end else begin
      wake_prev_ff <= nxt_wake_prev;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      irq_prev_ff <= 1'b0;
    end else begin
      irq_prev_ff <= nxt_irq_prev;
    end
  end

  // ----------------------------------------
  // event latch
  // ----------------------------------------
  always @* begin
    nxt_wake_latch = sticky(wake_latch_ff, wake_set, wake_clr);
  end

  always @* begin
    nxt_irq_latch = sticky(irq_latch_ff, irq_set, irq_clr);
  end

  always @(posedge CLK) begin
    if (RESET) begin
      wake_latch_ff <= 1'b0;
    end else begin
      wake_latch_ff <= nxt_wake_latch;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      irq_latch_ff <= 1'b0;
    end else begin
      irq_latch_ff <= nxt_irq_latch;
    end
  end

  // ----------------------------------------
  // mask register
  // ----------------------------------------
  // pm enable write beats a mask write in the same cycle
  always @* begin
    nxt_general_wake_mask = general_wake_mask_ff;
    if (wr_mask) begin
      // clearing here does not touch pm enable, which lives outside
      nxt_general_wake_mask = REG_WDATA[`CBFE_BIT_WAKE];
    end
    if (pm_wr) begin
      nxt_general_wake_mask = PM_EVENT_ENABLE;
    end
  end

  always @* begin
    nxt_wake_mask_bit = wake_mask_bit_ff;
    if (wr_mask) begin
      nxt_wake_mask_bit = REG_WDATA[`CBFE_BIT_WAKE_MASK];
    end
    if (pm_wr) begin
      nxt_wake_mask_bit = PM_EVENT_ENABLE;
    end
  end

  always @* begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_mask) begin
      nxt_irq_mask = REG_WDATA[`CBFE_BIT_IRQ];
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      general_wake_mask_ff <= 1'b0;
    end else begin
      general_wake_mask_ff <= nxt_general_wake_mask;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      wake_mask_bit_ff <= 1'b0;
    end else begin
      wake_mask_bit_ff <= nxt_wake_mask_bit;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      irq_mask_ff <= 1'b0;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // ----------------------------------------
  // pm status coupling
  // ----------------------------------------
  always @* begin
    nxt_pm_clr = sw_wake_one;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      pm_clr_ff <= 1'b0;
    end else begin
      pm_clr_ff <= nxt_pm_clr;
    end
  end

  // one-cycle pulse; the pm block keeps the status bit itself
  assign PM_STATUS_CLR = pm_clr_ff;

  // ----------------------------------------
  // pin gating
  // ----------------------------------------
  // pci mode or bypass: pins stay low, pm logic outside takes over
  assign wake_gate = general_wake_mask_ff & wake_mask_bit_ff;
  assign pin_irq = active & irq_latch_ff & irq_mask_ff;
  assign pin_wake = active & wake_latch_ff & wake_gate;
  assign CARD_IRQ_PIN = pin_irq;
  assign CARD_STATUS_CHANGE_PIN = pin_wake;

  // ----------------------------------------
  // read words
  // ----------------------------------------
  always @* begin
    latch_word = pack_events(wake_latch_ff, irq_latch_ff);
  end

  always @* begin
    mask_word = pack_events(general_wake_mask_ff, irq_mask_ff);
    mask_word[`CBFE_BIT_WAKE_MASK] = wake_mask_bit_ff;
  end

  always @* begin
    live_word = pack_events(WAKE_REQ, IRQ_REQ) | `CBFE_LIVE_CONST;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // force register has no storage, so it and unmapped offsets read zero
  always @* begin
    rd_mux = `CBFE_ZERO;
    if (rd) begin
      case (REG_ADDR)
        `CBFE_OFS_LATCH: begin
          rd_mux = latch_word;
        end
        `CBFE_OFS_MASK: begin
          rd_mux = mask_word;
        end
        `CBFE_OFS_LIVE: begin
          rd_mux = live_word;
        end
        default: begin
          rd_mux = `CBFE_ZERO;
        end
      endcase
    end
  end

  cbfe_rdreg u_rdreg (
    .CLK(CLK),
    .RESET(RESET),
    .d(rd_mux),
    .q(REG_RDATA)
  );
endmodule // cbfe_function_event_regs
`default_nettype wire

/* File: cbfe_host.sv */
`timescale 1ns/10ps
`default_nettype none
module cbfe_host (
  input wire logic go, wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] data,
  output wire logic REG_SEL, REG_WR, REG_RD,
  output wire logic [7:0] REG_ADDR,
  output wire logic [31:0] REG_WDATA
);
  assign REG_SEL = go;
  assign REG_WR = go && wr;
  assign REG_RD = go && !wr;
  assign REG_ADDR = addr;
  // driver keeps force bits 0 to 3 clear
  assign REG_WDATA = addr == 8'h0C ? data & 32'hFFFFFFF0 : data;
endmodule // cbfe_host
`default_nettype wire

/* File: cbfe_rdreg.v */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// registered read data
// ----------------------------------------
module cbfe_rdreg (
  // clock and reset
  input wire CLK,
  input wire RESET,
  // data
  input wire [31:0] d,
  output reg [31:0] q
);
  always @(posedge CLK) begin
    if (RESET) begin
      q <= 32'h00000000;
    end else begin
      q <= d;
    end
  end
endmodule // cbfe_rdreg
`default_nettype wire

/* File: cbfe_regs.vh */
`ifndef CBFE_REGS_VH
`define CBFE_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CBFE_OFS_LATCH 8'h00
`define CBFE_OFS_MASK 8'h04
`define CBFE_OFS_LIVE 8'h08
`define CBFE_OFS_FORCE 8'h0C
// ----------------------------------------
// field positions
// ----------------------------------------
`define CBFE_BIT_WAKE 4
`define CBFE_BIT_WAKE_MASK 14
`define CBFE_BIT_IRQ 15
// ----------------------------------------
// constant values
// ----------------------------------------
`define CBFE_LIVE_CONST 32'h0000000E
`define CBFE_ZERO 32'h00000000
`endif
